// [verilog/sxs_params.svh]
`ifndef SXS_PARAMS_SVH
`define SXS_PARAMS_SVH

// Word length and transfer type codes.
`define SXS_WORD_BITS      16
`define SXS_CNT_W          5
`define SXS_TT_REG         2'h0
`define SXS_TT_ACC_X       2'h1
`define SXS_TT_ACC_Y       2'h2
`define SXS_TT_BAD         2'h3

// Register operation codes carried in command bits 13:12.
`define SXS_OP_PTR_RD      2'h0
`define SXS_OP_PTR_WR      2'h1
`define SXS_OP_DAT_RD      2'h2
`define SXS_OP_DAT_WR      2'h3

// Device control register address, layout and reset value.
`define SXS_DEVICE_CONTROL_REG_ADDR    8'h0E
`define SXS_DEVICE_CONTROL_REG_RST     8'h00
`define SXS_CE_BIT         0
`define SXS_ST_LO_BIT      1
`define SXS_ST_HI_BIT      2

// Response field positions and fixed patterns.
`define SXS_ACC_P_BIT      12
`define SXS_REG_P_BIT      10
`define SXS_STAT_ERR       3'h7
`define SXS_REG_EXC_TAG    2'h2
`define SXS_PTR_WR_ACK     16'h0800

// Status codes returned in place of acceleration data.
`define SXS_CODE_CLK       11'h001
`define SXS_CODE_PAR       11'h002
`define SXS_CODE_AXIS      11'h004
`define SXS_CODE_FATAL     11'h7FF

`endif

// [verilog/sxs_pkg.sv]
package sxs_pkg;

    // Link sequencer states, Gray coded along idle, active, end.
    typedef enum logic [1:0] {
        SXS_LNK_IDLE   = 2'h0,
        SXS_LNK_ACTIVE = 2'h1,
        SXS_LNK_END    = 2'h3
    } sxs_link_state_t;

    // Exception that wins the priority contest, highest first.
    typedef enum logic [3:0] {
        SXS_EXC_CLK    = 4'h0,
        SXS_EXC_PAR    = 4'h1,
        SXS_EXC_IDE    = 4'h2,
        SXS_EXC_OSC    = 4'h3,
        SXS_EXC_INIT   = 4'h4,
        SXS_EXC_RESET  = 4'h5,
        SXS_EXC_TEMP   = 4'h6,
        SXS_EXC_AXIS   = 4'h7,
        SXS_EXC_BEHAV  = 4'h8,
        SXS_EXC_NONE   = 4'h9
    } sxs_exc_t;

endpackage

// [verilog/sxs_core.sv]
`include "sxs_params.svh"

// Function
// R1: Only the highest priority exception present is reported in a response.
// R2: After reset the block flags initialisation pending until init finishes.
// R3: After init, the latched reset flag holds until host writes clear-error.
// R4: Transient faults appear in the next transfer and clear themselves.
// R5: Self-test and hold never disturb register operations; reads complete.
// R6: Critical errors replace acceleration data with an invalid value.
// R7: Clear-error clears temperature fault only when temperature is back in range.
// R8: Fuse margin or register parity failure latches until device reset.
// R9: Oscillator fault forces serial output high whenever chip select is active.
// R10: First transfer after reset reports reset; later pre-init ones report init.
// R11: Initialisation pending clears by itself when initialisation completes.
// R12: Clock fault when rising edges differ from 16 or clock high at select.
// R13: Input word parity error is a transient fault reported next transfer.
// R14: Transfer type 11 gives an invalid axis transient fault.
// R15: Priority: clock, parity, data error, oscillator, init, reset, temp, axis, behaviour.
// R16: Hold and self-test share priority and are reported together; acceleration replies flag either one alone, and both at once read as none.
// R17: Transfers are 16 bits and a two bit type code selects the operation.
// R18: Type 00 register, 01 X axis, 10 Y axis, 11 unused.
// R19: Pointer and data writes are dropped if the same transfer faulted.
// R20: Self-test follows control register select bits; hold follows the hold pin.
// R21: Two status bits show behavioural conditions, nothing else changes.
// R22: Mode 0 slave, MSB first, host words carry odd parity.
// R23: Only the device control register accepts writes; others are silently ignored.
// R24: Transient flags latch at select release and clear once reported.
module sxs_core #(
    parameter int ACC_W = 11
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Serial link pins.
    input  wire logic             sclk_pin,
    input  wire logic             cs_n_pin,
    input  wire logic             din_pin,
    output logic                  dout,
    output logic                  dout_oe,
    // Monitors and hold pin.
    input  wire logic             init_done,
    input  wire logic             fuse_margin_fail,
    input  wire logic             reg_parity_fail,
    input  wire logic             osc_fault_det,
    input  wire logic             temp_out_of_range,
    input  wire logic             capture_hold_pin,
    // Data sources.
    input  wire logic [ACC_W-1:0] accel_x,
    input  wire logic [ACC_W-1:0] accel_y,
    input  wire logic [7:0]       reg_rd_data,
    // Register and status outputs.
    output logic [7:0]            reg_ptr,
    output logic [7:0]            device_control_reg,
    output logic                  internal_data_error_flag,
    output logic                  osc_fault_flag,
    output logic                  init_pending_flag,
    output logic                  reset_latched_flag,
    output logic                  overtemp_flag,
    output logic                  self_test_active,
    output logic                  hold_active
);

    // Two flop synchronisers for every pin; stage one is read only by stage two.
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 4'h2; // Idle pin levels, so no false edge follows reset.
            sync2_reg <= 4'h2;
        end else begin
            sync1_reg <= {capture_hold_pin, din_pin, cs_n_pin, sclk_pin};
            sync2_reg <= sync1_reg;
        end
    end

    wire sclk_s = sync2_reg[0];
    wire cs_n_s = sync2_reg[1];
    wire din_s  = sync2_reg[2];
    wire hold_s = sync2_reg[3];

    // Edge detection works on the synchronised copies only.
    logic sclk_d_reg;
    logic cs_n_d_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    wire cs_start  = ~cs_n_s & cs_n_d_reg;
    wire cs_stop   = cs_n_s & ~cs_n_d_reg;

    // Link sequencer and shift registers.
    sxs_pkg::sxs_link_state_t state_reg;
    sxs_pkg::sxs_link_state_t state_next;
    logic [15:0]              rx_reg;
    logic [15:0]              tx_reg;
    logic [`SXS_CNT_W-1:0]    cnt_reg;
    logic                     sclk_hi_at_start_reg;
    logic [15:0]              last_cmd_reg;
    logic                     first_done_reg;
    logic                     clk_fault_reg;
    logic                     par_fault_reg;
    logic                     axis_fault_reg;

    always_comb begin
        case (state_reg)
            sxs_pkg::SXS_LNK_IDLE:   state_next = cs_start ? sxs_pkg::SXS_LNK_ACTIVE
                                                           : sxs_pkg::SXS_LNK_IDLE;
            sxs_pkg::SXS_LNK_ACTIVE: state_next = cs_stop ? sxs_pkg::SXS_LNK_END
                                                          : sxs_pkg::SXS_LNK_ACTIVE;
            sxs_pkg::SXS_LNK_END:    state_next = sxs_pkg::SXS_LNK_IDLE;
            default:                 state_next = sxs_pkg::SXS_LNK_IDLE;
        endcase
    end

    // Faults of the transfer just ended, judged in the end state.
    wire cmd_clk_bad  = (cnt_reg != `SXS_CNT_W'(`SXS_WORD_BITS))
                        | sclk_hi_at_start_reg;                           // R12 R17
    wire cmd_par_bad  = ~(^rx_reg);                                       // R13 R22
    wire cmd_axis_bad = (rx_reg[15:14] == `SXS_TT_BAD);                   // R14 R18
    wire cmd_fault    = cmd_clk_bad | cmd_par_bad | cmd_axis_bad;
    wire at_end       = (state_reg == sxs_pkg::SXS_LNK_END);
    wire cmd_is_reg   = (rx_reg[15:14] == `SXS_TT_REG);                   // R18
    wire cmd_commit   = at_end & ~cmd_fault & cmd_is_reg;                 // R19
    wire ptr_wr       = cmd_commit & (rx_reg[13:12] == `SXS_OP_PTR_WR);
    wire dat_wr       = cmd_commit & (rx_reg[13:12] == `SXS_OP_DAT_WR);
    wire ctl_wr       = dat_wr & (reg_ptr == `SXS_DEVICE_CONTROL_REG_ADDR);           // R23
    wire ce_wr        = ctl_wr & rx_reg[`SXS_CE_BIT];

    // Sequencer state, bit counter and receive shift.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg            <= sxs_pkg::SXS_LNK_IDLE;
            cnt_reg              <= '0;
            rx_reg               <= 16'h0000;
            sclk_hi_at_start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (cs_start) begin
                cnt_reg              <= '0;
                sclk_hi_at_start_reg <= sclk_s;                           // R12
            end else if (state_reg == sxs_pkg::SXS_LNK_ACTIVE && sclk_rise) begin
                rx_reg <= {rx_reg[14:0], din_s};                          // R22
                if (cnt_reg != '1) begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

    // Behavioural conditions.
    assign self_test_active = device_control_reg[`SXS_ST_HI_BIT]
                              | device_control_reg[`SXS_ST_LO_BIT];      // R20
    assign hold_active      = hold_s;                                     // R20
    wire beh_one  = self_test_active ^ hold_active;
    wire beh_any  = self_test_active | hold_active;

    // Priority contest over everything pending at the start of a transfer.
    wire show_reset = reset_latched_flag | ~first_done_reg;               // R10
    wire show_init  = init_pending_flag & first_done_reg;                 // R10
    sxs_pkg::sxs_exc_t exc_sel;
    assign exc_sel = clk_fault_reg            ? sxs_pkg::SXS_EXC_CLK   :  // R15
                     par_fault_reg            ? sxs_pkg::SXS_EXC_PAR   :
                     internal_data_error_flag ? sxs_pkg::SXS_EXC_IDE   :
                     osc_fault_flag           ? sxs_pkg::SXS_EXC_OSC   :
                     show_init                ? sxs_pkg::SXS_EXC_INIT  :
                     show_reset               ? sxs_pkg::SXS_EXC_RESET :
                     overtemp_flag            ? sxs_pkg::SXS_EXC_TEMP  :
                     axis_fault_reg           ? sxs_pkg::SXS_EXC_AXIS  :
                     beh_any                  ? sxs_pkg::SXS_EXC_BEHAV :
                                                sxs_pkg::SXS_EXC_NONE;   // R1

    // Anything above the behavioural class counts as an error response.
    wire exc_err = (exc_sel < sxs_pkg::SXS_EXC_BEHAV);
    wire [10:0] exc_code = (exc_sel == sxs_pkg::SXS_EXC_CLK)  ? `SXS_CODE_CLK  :
                           (exc_sel == sxs_pkg::SXS_EXC_PAR)  ? `SXS_CODE_PAR  :
                           (exc_sel == sxs_pkg::SXS_EXC_AXIS) ? `SXS_CODE_AXIS :
                                                                `SXS_CODE_FATAL; // R6

    // Acceleration answer for the previous command.
    wire [1:0]  last_tt  = last_cmd_reg[15:14];
    wire        last_acc = (last_tt == `SXS_TT_ACC_X) | (last_tt == `SXS_TT_ACC_Y);
    wire [10:0] acc_val  = (last_tt == `SXS_TT_ACC_Y) ? 11'(accel_y) : 11'(accel_x);
    wire [15:0] acc_ok   = {beh_one, last_tt, 1'b0, acc_val, 1'b0};       // R5 R16 R21
    wire [15:0] acc_bad  = {`SXS_STAT_ERR, 1'b0, exc_code, 1'b0};         // R4 R6
    wire [15:0] acc_raw  = exc_err ? acc_bad : acc_ok;
    wire [15:0] acc_word = acc_raw | ({15'h0000, ~(^acc_raw)} << `SXS_ACC_P_BIT);

    // Register answer; an error only overwrites status fields, data still flows.
    wire [7:0]  rd_val  = (reg_ptr == `SXS_DEVICE_CONTROL_REG_ADDR) ? device_control_reg : reg_rd_data;
    logic [15:0] reg_base;
    always_comb begin
        case (last_cmd_reg[13:12])
            `SXS_OP_PTR_RD: reg_base = {8'h00, reg_ptr};
            `SXS_OP_PTR_WR: reg_base = `SXS_PTR_WR_ACK;
            `SXS_OP_DAT_RD: reg_base = {8'h10, rd_val};
            `SXS_OP_DAT_WR: reg_base = {8'h18, reg_ptr};
            default:        reg_base = 16'h0000;
        endcase
    end
    wire [1:0]  reg_tag  = exc_err ? `SXS_REG_EXC_TAG : {hold_active, self_test_active}; // R21
    wire [2:0]  reg_st   = exc_err ? `SXS_STAT_ERR : 3'h0;                // R6
    wire [15:0] reg_raw  = {reg_st, reg_base[12:10], reg_tag, reg_base[7:0]};  // R5
    wire        reg_nop  = (last_cmd_reg[13:12] == `SXS_OP_PTR_WR);
    wire [15:0] reg_word = reg_nop ? {reg_raw[15:11], 1'b0, reg_raw[9:0]}
                         : reg_raw | ({15'h0000, ~(^reg_raw)} << `SXS_REG_P_BIT);

    wire [15:0] resp_word = last_acc ? acc_word : reg_word;
    wire        bad_axis_last = (last_tt == `SXS_TT_BAD);

    // Transmit shift: load on select, advance on the falling clock edge.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_reg <= 16'h0000;
        end else if (cs_start) begin
            tx_reg <= bad_axis_last ? acc_word : resp_word;
        end else if (state_reg == sxs_pkg::SXS_LNK_ACTIVE && sclk_fall) begin
            tx_reg <= {tx_reg[14:0], 1'b0};                               // R22
        end
    end

    // Output pin: oscillator fault forces a high level for the whole select.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= ~cs_n_s;
            dout    <= osc_fault_flag ? 1'b1 : tx_reg[15];                // R9
        end
    end

    // Transient flags: caught at select release, dropped once loaded out.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clk_fault_reg  <= 1'b0;
            par_fault_reg  <= 1'b0;
            axis_fault_reg <= 1'b0;
        end else if (at_end) begin
            clk_fault_reg  <= cmd_clk_bad;                                // R24 R12
            par_fault_reg  <= cmd_par_bad;                                // R24 R13
            axis_fault_reg <= cmd_axis_bad;                               // R24 R14
        end else if (cs_start) begin
            clk_fault_reg  <= 1'b0;                                       // R4
            par_fault_reg  <= 1'b0;
            axis_fault_reg <= 1'b0;
        end
    end

    // Command history, pointer and control register updates.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            last_cmd_reg       <= 16'h0000;
            first_done_reg     <= 1'b0;
            reg_ptr            <= 8'h00;
            device_control_reg <= `SXS_DEVICE_CONTROL_REG_RST;
        end else begin
            if (at_end) begin
                last_cmd_reg   <= rx_reg;                                 // R17
                first_done_reg <= 1'b1;                                   // R10
            end
            if (ptr_wr) begin
                reg_ptr <= rx_reg[7:0];                                   // R19
            end
            if (ctl_wr) begin
                device_control_reg <= rx_reg[7:0];                        // R23
            end
        end
    end

    // Reset and critical flags; a new fault wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            init_pending_flag        <= 1'b1;
            reset_latched_flag       <= 1'b1;
            internal_data_error_flag <= 1'b0;
            osc_fault_flag           <= 1'b0;
            overtemp_flag            <= 1'b0;
        end else begin
            if (init_done) begin
                init_pending_flag <= 1'b0;                                // R2 R11
            end
            if (ce_wr && !init_pending_flag) begin
                reset_latched_flag <= 1'b0;                               // R3
            end
            if (fuse_margin_fail || reg_parity_fail) begin
                internal_data_error_flag <= 1'b1;                         // R8
            end
            if (osc_fault_det) begin
                osc_fault_flag <= 1'b1;                                   // R9
            end
            if (temp_out_of_range) begin
                overtemp_flag <= 1'b1;
            end else if (ce_wr) begin
                overtemp_flag <= 1'b0;                                    // R7
            end
        end
    end

endmodule

// [testbench/sxs_core_sva.sv]
module sxs_core_sva (
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Link pins and monitors.
    input wire logic       cs_n_pin,
    input wire logic       dout,
    input wire logic       dout_oe,
    input wire logic       init_done,
    input wire logic       fuse_margin_fail,
    input wire logic       reg_parity_fail,
    input wire logic       temp_out_of_range,
    input wire logic       capture_hold_pin,
    // Status outputs.
    input wire logic [7:0] device_control_reg,
    input wire logic       internal_data_error_flag,
    input wire logic       osc_fault_flag,
    input wire logic       init_pending_flag,
    input wire logic       reset_latched_flag,
    input wire logic       overtemp_flag,
    input wire logic       self_test_active,
    input wire logic       hold_active
);
    // Everything here lives in the system clock domain.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // The past terms skip the first fault cycle, where the forced level lags a cycle, and the first selected cycle.
    a_osc_forces_high: assert property (osc_fault_flag && $past(osc_fault_flag) && dout_oe
        && $past(dout_oe) |-> dout) else $error("dout low while selected with osc fault.");
    a_osc_sticky: assert property (osc_fault_flag |=> osc_fault_flag)
        else $error("Oscillator fault flag dropped without reset.");
    a_ide_sets: assert property ((fuse_margin_fail || reg_parity_fail)
        |-> ##[1:2] internal_data_error_flag) else $error("Data error flag not raised.");
    a_ide_sticky: assert property (internal_data_error_flag |=> internal_data_error_flag)
        else $error("Data error flag dropped without reset.");
    a_init_held: assert property (init_pending_flag && !init_done |=> init_pending_flag)
        else $error("Init pending dropped before init finished.");
    a_init_clears: assert property (init_done [*2] |=> !init_pending_flag)
        else $error("Init pending stuck after init finished.");
    a_reset_kept: assert property (reset_latched_flag && init_pending_flag
        |=> reset_latched_flag) else $error("Reset flag cleared during init.");
    a_temp_sets: assert property (temp_out_of_range |-> ##[1:2] overtemp_flag)
        else $error("Temperature flag not raised.");
    a_temp_kept: assert property (overtemp_flag && temp_out_of_range |=> overtemp_flag)
        else $error("Temperature flag cleared while still out of range.");
    a_hold_follows: assert property (capture_hold_pin [*3] |-> hold_active)
        else $error("Hold not active after hold pin high.");
    a_st_follows: assert property (self_test_active == (device_control_reg[2:1] != 2'h0))
        else $error("Self-test state differs from control bits.");
    a_oe_on_select: assert property ($fell(cs_n_pin) |-> ##[3:5] dout_oe)
        else $error("Output not enabled after select.");
    a_oe_off_idle: assert property (cs_n_pin [*5] |-> !dout_oe)
        else $error("Output enabled while deselected.");
endmodule

bind sxs_core sxs_core_sva sxs_core_sva_i (
    .sys_clk(sys_clk), .nrst(nrst), .cs_n_pin(cs_n_pin), .dout(dout), .dout_oe(dout_oe),
    .init_done(init_done), .fuse_margin_fail(fuse_margin_fail),
    .reg_parity_fail(reg_parity_fail), .temp_out_of_range(temp_out_of_range),
    .capture_hold_pin(capture_hold_pin), .device_control_reg(device_control_reg),
    .internal_data_error_flag(internal_data_error_flag), .osc_fault_flag(osc_fault_flag),
    .init_pending_flag(init_pending_flag), .reset_latched_flag(reset_latched_flag),
    .overtemp_flag(overtemp_flag), .self_test_active(self_test_active),
    .hold_active(hold_active));

// [testbench/sxs_host_model.sv]
module sxs_host_model (
    // Link lines driven by the host.
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    // Device reply.
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock idles low between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // One frame of n pulses at 160 ns, data set in the low phase, MSB first.
    // With hi set the clock stands high as select falls, which must give a clock fault.
    // The reply is taken at the end of the high phase, since dout moves a few cycles after the fall.
    task automatic xfer(input logic [15:0] cmd, input int n, input logic hi,
                        output logic [15:0] rsp);
        rsp = 16'h0000;
        sclk = hi;
        #80;
        cs_n = 1'b0;
        #80;
        sclk = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = (i < 16) ? cmd[15-i] : 1'b0;
            #80;
            sclk = 1'b1;
            #80;
            rsp = {rsp[14:0], dout};
            sclk = 1'b0;
        end
        #160;
        cs_n = 1'b1;
        din = ~din;
        #400;
    endtask
endmodule

// [testbench/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // Command words; spare bits keep the count of ones odd where wanted.
    localparam logic [15:0] ACC_X = 16'h4000;
    localparam logic [15:0] ACC_Y = 16'h8000;
    localparam logic [15:0] PTR_CTL = 16'h140E;
    localparam logic [15:0] ERR_RSP = 16'hFFFE;
    logic        sys_clk, nrst, sclk_pin, cs_n_pin, din_pin, dout, dout_oe;
    logic        init_done, fuse_margin_fail, reg_parity_fail, osc_fault_det;
    logic        temp_out_of_range, capture_hold_pin, internal_data_error_flag;
    logic        osc_fault_flag, init_pending_flag, reset_latched_flag, overtemp_flag;
    logic        self_test_active, hold_active;
    logic [10:0] accel_x, accel_y;
    logic [7:0]  reg_rd_data, reg_ptr, device_control_reg;
    logic [15:0] r;
    int          err_count, compares;
    logic [15:0] bad [6] = '{16'h8000, 16'h4000, 16'h4001, 16'hC001, 16'hC000, 16'h4000};
    int          nclk [6] = '{15, 17, 16, 16, 15, 16};
    logic [10:0] code [6] = '{11'h001, 11'h001, 11'h002, 11'h004, 11'h001, 11'h001};

    sxs_core sxs_core_i (.sys_clk(sys_clk), .nrst(nrst), .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout(dout), .dout_oe(dout_oe),
        .init_done(init_done), .fuse_margin_fail(fuse_margin_fail),
        .reg_parity_fail(reg_parity_fail), .osc_fault_det(osc_fault_det),
        .temp_out_of_range(temp_out_of_range), .capture_hold_pin(capture_hold_pin),
        .accel_x(accel_x), .accel_y(accel_y), .reg_rd_data(reg_rd_data), .reg_ptr(reg_ptr),
        .device_control_reg(device_control_reg),
        .internal_data_error_flag(internal_data_error_flag), .osc_fault_flag(osc_fault_flag),
        .init_pending_flag(init_pending_flag), .reset_latched_flag(reset_latched_flag),
        .overtemp_flag(overtemp_flag), .self_test_active(self_test_active),
        .hold_active(hold_active));
    sxs_host_model sxs_host_model_i (.sclk(sclk_pin), .cs_n(cs_n_pin), .din(din_pin),
        .dout(dout));

    // System clock, 20 ns period.
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // Inputs move a fixed 2 ns after the edge so no race with the sampling flops.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    // Frames start 2 ns after an edge too, so no link pin moves on a sampling edge.
    task automatic xf(input logic [15:0] cmd, input int n = 16, input logic hi = 1'b0);
        tick(1);
        sxs_host_model_i.xfer(cmd, n, hi, r);
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // Acceleration reply; an error reply is status 1 with type 11 and the code as data.
    function automatic logic [15:0] acc_ok(input logic s2, input logic [1:0] t,
                                           input logic [10:0] d);
        logic [15:0] w;
        w = {s2, t, 1'b0, d, 1'b0};
        w[12] = ~^w;
        return w;
    endfunction

    task automatic complete_run();
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under this.
    initial begin
        #1ms;
        err_count++;
        complete_run();
    end

    // Main sequence.
    initial begin
        {nrst, init_done, fuse_margin_fail, reg_parity_fail, osc_fault_det} = 5'h00;
        {temp_out_of_range, capture_hold_pin} = 2'h0;
        accel_x = 11'h2A5;
        accel_y = 11'h15A;
        reg_rd_data = 8'h3C;
        err_count = 0;
        compares = 0;
        tick(1);
        chk_bit(init_pending_flag, 1'b1);
        chk_bit(reset_latched_flag, 1'b1);
        tick(19);
        nrst = 1'b1;
        tick(3);
        xf(ACC_X);
        chk_word(r & 16'hE000, 16'hE000);
        xf(ACC_X);
        chk_word(r, ERR_RSP);
        tick(1);
        init_done = 1'b1;
        tick(3);
        chk_bit(init_pending_flag, 1'b0);
        xf(ACC_X);
        chk_word(r, ERR_RSP);
        xf(PTR_CTL);
        xf(16'h3001);
        chk_bit(reset_latched_flag, 1'b0);
        chk_word({8'h00, reg_ptr}, 16'h000E);
        xf(ACC_X);
        xf(ACC_Y);
        chk_word(r, acc_ok(1'b0, 2'h1, accel_x));
        xf(ACC_X);
        chk_word(r, acc_ok(1'b0, 2'h2, accel_y));
        // Faulty frame, then its report, then a clean reply again.
        for (int k = 0; k < 6; k++) begin
            xf(bad[k], nclk[k], k == 5);
            xf(ACC_X);
            chk_word(r, acc_ok(1'b1, 2'h3, code[k]));
            xf(ACC_X);
            chk_word(r, acc_ok(1'b0, 2'h1, accel_x));
        end
        xf(16'h1405);
        chk_word({8'h00, reg_ptr}, 16'h000E);
        xf(16'h1005);
        chk_word({8'h00, reg_ptr}, 16'h0005);
        xf(16'h34FF);
        xf(16'h2000);
        xf(PTR_CTL);
        chk_word(r, 16'h103C);
        chk_bit(self_test_active, 1'b0);
        tick(1);
        capture_hold_pin = 1'b1;
        tick(4);
        chk_bit(hold_active, 1'b1);
        xf(ACC_X);
        xf(ACC_X);
        chk_word(r, acc_ok(1'b1, 2'h1, accel_x));
        xf(16'h3002);
        chk_bit(self_test_active, 1'b1);
        xf(ACC_X);
        xf(ACC_X);
        chk_word(r, acc_ok(1'b0, 2'h1, accel_x));
        tick(1);
        capture_hold_pin = 1'b0;
        xf(16'h3400);
        tick(1);
        temp_out_of_range = 1'b1;
        tick(2);
        chk_bit(overtemp_flag, 1'b1);
        xf(ACC_X);
        xf(ACC_X);
        chk_word(r, ERR_RSP);
        xf(16'h3001);
        chk_bit(overtemp_flag, 1'b1);
        tick(1);
        temp_out_of_range = 1'b0;
        xf(16'h3001);
        chk_bit(overtemp_flag, 1'b0);
        tick(1);
        fuse_margin_fail = 1'b1;
        tick(1);
        fuse_margin_fail = 1'b0;
        xf(16'h3001);
        xf(ACC_X);
        xf(ACC_X);
        chk_bit(internal_data_error_flag, 1'b1);
        chk_word(r, ERR_RSP);
        tick(1);
        osc_fault_det = 1'b1;
        tick(1);
        osc_fault_det = 1'b0;
        xf(ACC_Y);
        chk_word(r, 16'hFFFF);
        tick(1);
        nrst = 1'b0;
        tick(20);
        nrst = 1'b1;
        tick(3);
        chk_bit(osc_fault_flag, 1'b0);
        chk_bit(internal_data_error_flag, 1'b0);
        reg_parity_fail = 1'b1;
        tick(1);
        reg_parity_fail = 1'b0;
        tick(2);
        chk_bit(internal_data_error_flag, 1'b1);
        complete_run();
    end
endmodule
